// ==== shared/liu_alarm_pkg.sv ====
// Package: register map, field positions, reset values and counts of the line alarm block
package liu_alarm_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0F04;
    localparam logic [13:0] IDX_LIVE_STATUS = 14'h0F05;
    localparam logic [13:0] IDX_CHANGE_LATCHES = 14'h0F06;
    localparam logic [13:0] IDX_LATCH_CLEAR = 14'h0F07;

    // ------------------------------------------------------------
    // Field positions, shared by status, latch and enable registers
    // ------------------------------------------------------------
    localparam int BIT_PATTERN_LOCK = 0;
    localparam int BIT_SIGNAL_LOSS = 1;
    localparam int BIT_LOOP_CODE = 3;
    localparam int BIT_FIFO_LIMIT = 5;
    localparam int BIT_DRIVER_MONITOR = 6;

    // Bits that carry a function; 7, 4 and 2 never do
    localparam logic [7:0] DEFINED_MASK = 8'h6B;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_LATCHES = 8'h00;
    localparam logic [7:0] RESET_ENABLE = 8'h00;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int DMO_QUIET_BITS = 128;
    localparam int FIFO_LIMIT_SPAN = 3;
    localparam int SYNC_STAGES = 3;

endpackage

// ==== rtl/alarm_pin_sync.sv ====
// Three-stage synchroniser for asynchronous alarm pins with agreement filter
`timescale 1ns/100ps

module alarm_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_clean
);
    import liu_alarm_pkg::*;

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] clean_q;

    // ------------------------------------------------------------
    // Synchroniser chain, one lane per pin
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : lane
            // Stage 1 feeds stage 2 only, to keep metastability contained
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    stage1_q[g] <= 1'b0;
                    stage2_q[g] <= 1'b0;
                    stage3_q[g] <= 1'b0;
                end else begin
                    stage1_q[g] <= pin_async[g];
                    stage2_q[g] <= stage1_q[g];
                    stage3_q[g] <= stage2_q[g];
                end
            end

            // A change counts once stages two and three agree
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    clean_q[g] <= 1'b0;
                end else if (stage2_q[g] == stage3_q[g]) begin
                    clean_q[g] <= stage3_q[g];
                end
            end
        end
    endgenerate

    assign pin_clean = clean_q;

endmodule

// ==== rtl/liu_alarm_status_irq_latch.sv ====
// Line interface alarm status, change latches and interrupt request with a Wishbone slave
`timescale 1ns/100ps

// ----------------------------------------------------------------
// ----------------------------------------------------------------

module liu_alarm_status_irq_latch #(
    parameter int PTR_W = 5
) (
    input wire logic clk,
    input wire logic reset,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Receive side alarm pins, asynchronous to clk
    input wire logic rx_signal_loss_flag,
    input wire logic test_pattern_lock_flag,
    input wire logic loop_code_detect_flag,
    // Transmit line monitor, on clk
    input wire logic tx_bit_tick,
    input wire logic tx_pulse_pos,
    input wire logic tx_pulse_neg,
    // Jitter attenuator pointers, on clk
    input wire logic [PTR_W-1:0] jitter_wr_ptr,
    input wire logic [PTR_W-1:0] jitter_rd_ptr,
    // Interrupt request
    output logic irq
);
    import liu_alarm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] pin_clean;
    logic rx_loss_s;
    logic pattern_lock_s;
    logic loop_code_s;

    logic [7:0] quiet_cnt_q;
    logic driver_monitor_alarm_q;
    logic jitter_fifo_limit_flag_q;
    logic [PTR_W-1:0] ptr_gap;

    logic [7:0] live_d;
    logic [7:0] live_q;
    logic [7:0] prev_q;
    logic prev_valid_q;
    logic [7:0] change;

    logic [7:0] latches_d;
    logic [7:0] latches_q;
    logic [7:0] enable_q;
    logic irq_q;

    logic bus_req;
    logic ack_q;
    logic [31:0] dat_q;
    logic rd_take;
    logic wr_take;
    logic [13:0] req_idx;
    logic latch_read;
    logic [7:0] latch_wclear;

    // Decode a register index from a byte address
    function automatic logic [13:0] reg_index(input logic [15:0] adr);
        reg_index = adr[15:2];
    endfunction

    // True when a request selects the given register
    function automatic logic hits(input logic [15:0] adr, input logic [13:0] idx);
        hits = (reg_index(adr) == idx);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    alarm_pin_sync #(
        .WIDTH(3)
    ) pin_sync (
        .clk(clk),
        .reset(reset),
        .pin_async({loop_code_detect_flag, test_pattern_lock_flag, rx_signal_loss_flag}),
        .pin_clean(pin_clean)
    );

    assign rx_loss_s = pin_clean[0];
    assign pattern_lock_s = pin_clean[1];
    assign loop_code_s = pin_clean[2];

    // ------------------------------------------------------------
    // Driver monitor
    // ------------------------------------------------------------
    // Count quiet bit periods; a pulse clears at once, even mid-period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            quiet_cnt_q <= 8'h00;
            driver_monitor_alarm_q <= 1'b0;
        end else if (tx_pulse_pos || tx_pulse_neg) begin
            quiet_cnt_q <= 8'h00;
            driver_monitor_alarm_q <= 1'b0;
        end else if (tx_bit_tick && !driver_monitor_alarm_q) begin
            if (quiet_cnt_q == 8'(DMO_QUIET_BITS - 1)) begin
                driver_monitor_alarm_q <= 1'b1;
                quiet_cnt_q <= 8'h00;
            end else begin
                quiet_cnt_q <= quiet_cnt_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Jitter FIFO limit
    // ------------------------------------------------------------
    // Pointer gap wraps modulo the FIFO depth, so both signs are checked
    assign ptr_gap = jitter_wr_ptr - jitter_rd_ptr;

    // Registered so the flag is a clean level for change detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            jitter_fifo_limit_flag_q <= 1'b0;
        end else begin
            jitter_fifo_limit_flag_q <= (ptr_gap <= PTR_W'(FIFO_LIMIT_SPAN)) ||
                                        (ptr_gap >= PTR_W'(-FIFO_LIMIT_SPAN));
        end
    end

    // ------------------------------------------------------------
    // Live status
    // ------------------------------------------------------------
    // Assemble live flags; undefined positions stay 0
    always_comb begin
        live_d = 8'h00;
        live_d[BIT_PATTERN_LOCK] = pattern_lock_s;
        live_d[BIT_SIGNAL_LOSS] = rx_loss_s;
        live_d[BIT_LOOP_CODE] = loop_code_s;
        live_d[BIT_FIFO_LIMIT] = jitter_fifo_limit_flag_q;
        live_d[BIT_DRIVER_MONITOR] = driver_monitor_alarm_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            live_q <= RESET_STATUS;
        end else begin
            live_q <= live_d;
        end
    end

    // ------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------
    // First sample after reset is compared against RESET_STATUS; only the first cycle after reset is masked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_q <= RESET_STATUS;
            prev_valid_q <= 1'b0;
        end else begin
            prev_q <= live_q;
            prev_valid_q <= 1'b1;
        end
    end

    // Either edge of a flag counts; both directions are reportable events
    assign change = prev_valid_q ? ((live_q ^ prev_q) & DEFINED_MASK) : 8'h00;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign req_idx = reg_index(wb_adr_i);
    assign rd_take = bus_req && !ack_q && !wb_we_i;
    // Writes land at the ack edge, where the master samples the answer
    assign wr_take = bus_req && ack_q && wb_we_i;

    // One wait state: ack one cycle after the request, dropped the next
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // Read data; unmapped and write-only addresses read as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dat_q <= 32'h0000_0000;
        end else if (rd_take) begin
            case (req_idx)
                IDX_IRQ_ENABLE: dat_q <= {24'h00_0000, enable_q};
                IDX_LIVE_STATUS: dat_q <= {24'h00_0000, live_q};
                IDX_CHANGE_LATCHES: dat_q <= {24'h00_0000, latches_q};
                default: dat_q <= 32'h0000_0000;
            endcase
        end
    end

    // Enable register steers the interrupt output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_q <= RESET_ENABLE;
        end else if (wr_take && wb_sel_i[0] && hits(wb_adr_i, IDX_IRQ_ENABLE)) begin
            enable_q <= wb_dat_i[7:0] & DEFINED_MASK;
        end
    end

    // ------------------------------------------------------------
    // Change latches
    // ------------------------------------------------------------
    // The read clears what the master saw: the value sampled into dat_q
    assign latch_read = rd_take && hits(wb_adr_i, IDX_CHANGE_LATCHES);

    // Write-one-to-clear companion; unused bits are masked off
    assign latch_wclear = (wr_take && wb_sel_i[0] && hits(wb_adr_i, IDX_LATCH_CLEAR)) ?
                          (wb_dat_i[7:0] & DEFINED_MASK) : 8'h00;

    // Set wins over clear so a change during the read is not lost
    always_comb begin
        latches_d = latches_q;
        if (latch_read) begin
            latches_d = 8'h00;
        end
        latches_d = latches_d & ~latch_wclear;
        latches_d = latches_d | change;
        latches_d = latches_d & DEFINED_MASK;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latches_q <= RESET_LATCHES;
        end else begin
            latches_q <= latches_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Level output, registered so the pin never glitches
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(latches_q & enable_q);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq = irq_q;

endmodule

// ==== testbench/liu_alarm_monitor.sv ====
// Checker for the bus replies, live status, driver monitor, FIFO limit and interrupt of the line alarm block
`timescale 1ns/100ps

module liu_alarm_monitor
    import liu_alarm_pkg::*;
#(
    parameter int PTR_W = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rx_signal_loss_flag,
    input wire logic test_pattern_lock_flag,
    input wire logic loop_code_detect_flag,
    input wire logic tx_bit_tick,
    input wire logic tx_pulse_pos,
    input wire logic tx_pulse_neg,
    input wire logic [PTR_W-1:0] jitter_wr_ptr,
    input wire logic [PTR_W-1:0] jitter_rd_ptr,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [7:0] quiet_ticks_q;
    logic [2:0] pulse_age_q;
    logic [7:0] en_shadow_q;
    logic [PTR_W-1:0] ptr_gap;
    logic gap_near;
    logic live_rd;
    logic latch_rd;
    logic en_rd;
    assign ptr_gap = jitter_wr_ptr - jitter_rd_ptr;
    assign gap_near = (ptr_gap <= PTR_W'(3)) || (ptr_gap >= PTR_W'(2 ** PTR_W - 3));
    assign live_rd = wb_ack_o && !wb_we_i && wb_adr_i[15:2] == IDX_LIVE_STATUS;
    assign latch_rd = wb_ack_o && !wb_we_i && wb_adr_i[15:2] == IDX_CHANGE_LATCHES;
    assign en_rd = wb_ack_o && !wb_we_i && wb_adr_i[15:2] == IDX_IRQ_ENABLE;

    // Ticks and cycles since the last pulse; saturating so long quiet runs stay valid
    always_ff @(posedge clk or posedge reset) begin
        if (reset || tx_pulse_pos || tx_pulse_neg) begin
            quiet_ticks_q <= 8'h00;
            pulse_age_q <= 3'h0;
        end else begin
            if (tx_bit_tick && quiet_ticks_q != 8'hFF) quiet_ticks_q <= quiet_ticks_q + 8'h01;
            if (pulse_age_q != 3'h7) pulse_age_q <= pulse_age_q + 3'h1;
        end
    end

    // Enable copy taken at the ack edge, the same edge at which the design stores it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) en_shadow_q <= 8'h00;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[15:2] == IDX_IRQ_ENABLE) en_shadow_q <= wb_dat_i[7:0];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_live_rsvd; live_rd |-> (wb_dat_o[7:0] & ~DEFINED_MASK) == 8'h00; endproperty
    a_live_rsvd: assert property (p_live_rsvd) else $error("live status unused bit set");
    property p_latch_rsvd; latch_rd |-> (wb_dat_o[7:0] & ~DEFINED_MASK) == 8'h00; endproperty
    a_latch_rsvd: assert property (p_latch_rsvd) else $error("latch unused bit set");
    property p_en_rsvd; en_rd |-> (wb_dat_o[7:0] & ~DEFINED_MASK) == 8'h00; endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("enable unused bit set");
    property p_dmo_set; live_rd && quiet_ticks_q >= 8'd132 |-> wb_dat_o[BIT_DRIVER_MONITOR]; endproperty
    a_dmo_set: assert property (p_dmo_set) else $error("driver alarm missing after quiet run");
    property p_dmo_clear;
        live_rd && pulse_age_q >= 3'h3 && quiet_ticks_q <= 8'd126 |-> !wb_dat_o[BIT_DRIVER_MONITOR];
    endproperty
    a_dmo_clear: assert property (p_dmo_clear) else $error("driver alarm without quiet run");
    property p_fifo_flag;
        ($stable(jitter_wr_ptr) && $stable(jitter_rd_ptr))[*4] ##0 live_rd |-> wb_dat_o[BIT_FIFO_LIMIT] == gap_near;
    endproperty
    a_fifo_flag: assert property (p_fifo_flag) else $error("fifo limit flag wrong");
    property p_live_pins;
        ($stable(rx_signal_loss_flag) && $stable(test_pattern_lock_flag))[*8] ##0 live_rd
        |-> wb_dat_o[1:0] == {rx_signal_loss_flag, test_pattern_lock_flag};
    endproperty
    a_live_pins: assert property (p_live_pins) else $error("live pin status wrong");
    property p_irq_masked; ((en_shadow_q & DEFINED_MASK) == 8'h00)[*2] |-> !irq; endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all enables off");

    c_dmo: cover property (live_rd && wb_dat_o[BIT_DRIVER_MONITOR]);
    c_latch: cover property (latch_rd && wb_dat_o[7:0] != 8'h00);
    c_irq: cover property ($rose(irq));
endmodule

// ==== testbench/liu_alarm_status_irq_latch_test.sv ====
// Self-checking bench for the line alarm status, change latches and interrupt
`timescale 1ns/100ps

module liu_alarm_status_irq_latch_test;
    import liu_alarm_pkg::*;
    localparam int PTR_W = 5;
    localparam logic [15:0] A_EN = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [15:0] A_ST = {IDX_LIVE_STATUS, 2'b00};
    localparam logic [15:0] A_LT = {IDX_CHANGE_LATCHES, 2'b00};
    localparam logic [15:0] A_CL = {IDX_LATCH_CLEAR, 2'b00};
    logic clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq;
    logic rx_signal_loss_flag = 1'b0, test_pattern_lock_flag = 1'b0, loop_code_detect_flag = 1'b0;
    logic tx_bit_tick = 1'b0, tx_pulse_pos = 1'b0, tx_pulse_neg = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
    logic [PTR_W-1:0] jitter_wr_ptr = 5'h0A, jitter_rd_ptr = 5'h00;
    logic [PTR_W-1:0] wtab [4] = '{5'h03, 5'h04, 5'h01, 5'h00};
    logic [PTR_W-1:0] rtab [4] = '{5'h00, 5'h00, 5'h04, 5'h04};
    logic [7:0] etab [4] = '{8'h28, 8'h08, 8'h28, 8'h08};
    int err_count = 0;
    int checks_done = 0;

    liu_alarm_status_irq_latch #(.PTR_W(PTR_W)) u_dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_signal_loss_flag(rx_signal_loss_flag),
        .test_pattern_lock_flag(test_pattern_lock_flag), .loop_code_detect_flag(loop_code_detect_flag),
        .tx_bit_tick(tx_bit_tick), .tx_pulse_pos(tx_pulse_pos), .tx_pulse_neg(tx_pulse_neg),
        .jitter_wr_ptr(jitter_wr_ptr), .jitter_rd_ptr(jitter_rd_ptr), .irq(irq));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    // One classic cycle; a missing ack is bounded so a dead slave cannot hang the run
    task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            chk("wb ack", 8'h01, 8'h00);
            give_verdict();
        end
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] adr, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, adr, d, q);
    endtask

    task automatic rd(input logic [15:0] adr, input logic [7:0] exp, input string name);
        logic [7:0] q;
        wb_xfer(1'b0, adr, 8'h00, q);
        chk(name, exp, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        // Line interface and framer are taken to sit in single-rail mode throughout
        idle(3);
        reset <= 1'b0;
        rd(A_ST, 8'h00, "status at reset");
        rd(A_LT, 8'h00, "latches at reset");
        rd(A_EN, 8'h00, "enable at reset");
        rd(16'h3C00, 8'h00, "unmapped read");
        $display("test reset values done");
        rx_signal_loss_flag <= 1'b1;
        test_pattern_lock_flag <= 1'b1;
        loop_code_detect_flag <= 1'b1;
        idle(10);
        rd(A_ST, 8'h0B, "live pins");
        rd(A_LT, 8'h0B, "latches after pin rise");
        rd(A_LT, 8'h00, "latches after read");
        $display("test pin latches done");
        wr(A_EN, 8'hFF);
        rd(A_EN, 8'h6B, "enable defined bits");
        wr(A_LT, 8'hFF);
        rd(A_LT, 8'h00, "latch write ignored");
        chk("irq idle", 8'h00, {7'h00, irq});
        rx_signal_loss_flag <= 1'b0;
        idle(10);
        chk("irq on loss fall", 8'h01, {7'h00, irq});
        wr(A_EN, 8'h01);
        idle(2);
        chk("irq masked", 8'h00, {7'h00, irq});
        test_pattern_lock_flag <= 1'b0;
        idle(10);
        chk("irq on lock fall", 8'h01, {7'h00, irq});
        wr(A_CL, 8'h01);
        idle(2);
        chk("irq after clear", 8'h00, {7'h00, irq});
        rd(A_LT, 8'h02, "latches after clear");
        $display("test interrupt done");
        // Just short of the quiet run, then past it
        tx_bit_tick <= 1'b1;
        idle(127);
        tx_bit_tick <= 1'b0;
        idle(4);
        rd(A_ST, 8'h08, "driver alarm at 127");
        tx_bit_tick <= 1'b1;
        idle(10);
        tx_bit_tick <= 1'b0;
        idle(4);
        rd(A_ST, 8'h48, "driver alarm set");
        rd(A_LT, 8'h40, "driver latch set");
        tx_pulse_neg <= 1'b1;
        idle(1);
        tx_pulse_neg <= 1'b0;
        idle(4);
        rd(A_ST, 8'h08, "driver alarm cleared");
        rd(A_LT, 8'h40, "driver latch on clear");
        $display("test driver monitor done");
        // Pointer gaps on both sides of the limit, including wrap-around
        for (int i = 0; i < 4; i++) begin
            jitter_wr_ptr <= wtab[i];
            jitter_rd_ptr <= rtab[i];
            idle(4);
            rd(A_ST, etab[i], "fifo limit");
        end
        rd(A_LT, 8'h20, "fifo latch");
        $display("test fifo limit done");
        give_verdict();
    end
endmodule

// ----------------------------------------------------------------
// Checker attached to the block
// ----------------------------------------------------------------
bind liu_alarm_status_irq_latch liu_alarm_monitor #(.PTR_W(PTR_W)) u_mon (.clk(clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_signal_loss_flag(rx_signal_loss_flag),
    .test_pattern_lock_flag(test_pattern_lock_flag), .loop_code_detect_flag(loop_code_detect_flag),
    .tx_bit_tick(tx_bit_tick), .tx_pulse_pos(tx_pulse_pos), .tx_pulse_neg(tx_pulse_neg),
    .jitter_wr_ptr(jitter_wr_ptr), .jitter_rd_ptr(jitter_rd_ptr), .irq(irq));
